//--- rtl/jtb_pkg.sv
package jtb_pkg;
   // ***************************************************************
   // tap controller states
   // ***************************************************************
   typedef enum logic [3:0] {
      JTB_TLR, JTB_RTI, JTB_SEL_DR, JTB_CAP_DR, JTB_SH_DR, JTB_EX1_DR, JTB_PA_DR, JTB_EX2_DR, JTB_UPD_DR,
      JTB_SEL_IR, JTB_CAP_IR, JTB_SH_IR, JTB_EX1_IR, JTB_PA_IR, JTB_EX2_IR, JTB_UPD_IR
   } jtb_tap_state_t;

   // ***************************************************************
   // widths, codes and reset values
   // ***************************************************************
   localparam int          JTB_IR_W         = 4;
   localparam int          JTB_ID_W         = 32;
   localparam int          JTB_USER_W       = 8;
   localparam logic [3:0]  JTB_IR_BYPASS    = 4'hF;
   localparam logic [3:0]  JTB_IR_IDCODE    = 4'h1;
   localparam logic [3:0]  JTB_IR_USER      = 4'h2;
   localparam logic [3:0]  JTB_IR_CAPTURE   = 4'h1;
   localparam logic [31:0] JTB_ID_DEFAULT   = 32'h1234_5671; // arbitrary value
   localparam logic [1:0]  JTB_BUF_DEPTH    = 2'h2;
   // synchroniser reset: float request at its idle high level, all else low
   localparam logic [4:0]  JTB_SYNC_RESET   = 5'h10;
endpackage

//--- rtl/jtb_word_if.sv
`timescale 1ns/10ps
interface jtb_word_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

//--- rtl/jtb_word_buf.sv
`timescale 1ns/10ps
module jtb_word_buf #(
   parameter int W = 8
) (
   input  wire logic         clock_in,
   input  wire logic         resetn_in,
   jtb_word_if.snk           fill,
   output logic              valid_out,
   output logic [W-1:0]      data_out,
   input  wire logic         ready_in
);
   // ***************************************************************
   // two entries: head drives the output, tail holds the second word
   // ***************************************************************
   logic [W-1:0] tail_r;
   logic [1:0]   count_r;
   logic         push;
   logic         pop;

   assign fill.ready = (count_r != jtb_pkg::JTB_BUF_DEPTH);
   assign push       = fill.valid && fill.ready;
   assign pop        = valid_out && ready_in;

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         count_r   <= 2'h0;
         valid_out <= 1'b0;
         data_out  <= '0;
         tail_r    <= '0;
      end else begin
         if (push && !pop) begin
            if (count_r == 2'h0) data_out <= fill.data;
            else tail_r <= fill.data;
            count_r   <= count_r + 2'h1;
            valid_out <= 1'b1;
         end else if (pop && !push) begin
            data_out  <= tail_r;
            count_r   <= count_r - 2'h1;
            valid_out <= (count_r == jtb_pkg::JTB_BUF_DEPTH);
         end else if (push && pop) begin
            if (count_r == 2'h1) data_out <= fill.data;
            else begin
               data_out <= tail_r;
               tail_r   <= fill.data;
            end
         end
      end
   end

   no_overflow_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
      count_r <= jtb_pkg::JTB_BUF_DEPTH) else $error("buffer count above depth");
endmodule

//--- rtl/jtb_test_port.sv
`timescale 1ns/10ps
// Function
// R1: mode select sampled on each rising test clock edge steers the state machine.
// R2: data input sampled on rising test clock shifts into the selected register.
// R3: serial output shows selected register bit and changes only after falling test clock.
// R4: serial output floats whenever no register is being shifted.
// R5: output enable changes only after a falling test clock edge.
// R6: test reset low forces reset state and floats the serial output.
// R7: controller keeps test reset high whenever scan operation is wanted.
// R8: controller holds test reset low until power is stable.
// R9: float input low with test reset low floats every output pin.
// R10: sixteen-state sequence; shift one bit per test clock between capture and update.
module jtb_test_port #(
   parameter logic [31:0] ID_CODE = jtb_pkg::JTB_ID_DEFAULT, // arbitrary value
   parameter int          USER_W  = jtb_pkg::JTB_USER_W
) (
   input  wire logic              clock_in,
   input  wire logic              resetn_in,
   input  wire logic              test_port_clock_in,
   input  wire logic              test_mode_select_in,
   input  wire logic              test_serial_data_in,
   input  wire logic              test_port_reset_n_in,
   input  wire logic              float_all_outputs_n_in,
   output logic                   test_serial_data_out,
   output logic                   test_serial_data_oe_out,
   output logic                   float_all_outputs_out,
   output logic                   word_valid_out,
   output logic [USER_W-1:0]      word_data_out,
   input  wire logic              word_ready_in
);
   // ***************************************************************
   // pin synchronisers and test clock edges
   // ***************************************************************
   logic [4:0]                    sync1_r;
   logic [4:0]                    sync2_r;
   logic                          tck_d_r;
   logic                          tck_s, tms_s, tdi_s, trst_s, hiz_s;
   logic                          tck_rise, tck_fall;

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         // a low float request here would pulse the pin float flag after reset
         sync1_r <= jtb_pkg::JTB_SYNC_RESET;
         sync2_r <= jtb_pkg::JTB_SYNC_RESET;
         tck_d_r <= 1'b0;
      end else begin
         sync1_r <= {float_all_outputs_n_in, test_port_reset_n_in, test_serial_data_in,
                     test_mode_select_in, test_port_clock_in};
         sync2_r <= sync1_r;
         tck_d_r <= sync2_r[0];
      end
   end

   assign {hiz_s, trst_s, tdi_s, tms_s, tck_s} = sync2_r;
   assign tck_rise = tck_s && !tck_d_r;
   assign tck_fall = !tck_s && tck_d_r;

   // ***************************************************************
   // tap state machine
   // ***************************************************************
   jtb_pkg::jtb_tap_state_t state_r, state_nxt;

   always_comb begin
      case (state_r)
         jtb_pkg::JTB_TLR:    state_nxt = tms_s ? jtb_pkg::JTB_TLR    : jtb_pkg::JTB_RTI;
         jtb_pkg::JTB_RTI:    state_nxt = tms_s ? jtb_pkg::JTB_SEL_DR : jtb_pkg::JTB_RTI;
         jtb_pkg::JTB_SEL_DR: state_nxt = tms_s ? jtb_pkg::JTB_SEL_IR : jtb_pkg::JTB_CAP_DR;
         jtb_pkg::JTB_CAP_DR: state_nxt = tms_s ? jtb_pkg::JTB_EX1_DR : jtb_pkg::JTB_SH_DR;
         jtb_pkg::JTB_SH_DR:  state_nxt = tms_s ? jtb_pkg::JTB_EX1_DR : jtb_pkg::JTB_SH_DR;
         jtb_pkg::JTB_EX1_DR: state_nxt = tms_s ? jtb_pkg::JTB_UPD_DR : jtb_pkg::JTB_PA_DR;
         jtb_pkg::JTB_PA_DR:  state_nxt = tms_s ? jtb_pkg::JTB_EX2_DR : jtb_pkg::JTB_PA_DR;
         jtb_pkg::JTB_EX2_DR: state_nxt = tms_s ? jtb_pkg::JTB_UPD_DR : jtb_pkg::JTB_SH_DR;
         jtb_pkg::JTB_UPD_DR: state_nxt = tms_s ? jtb_pkg::JTB_SEL_DR : jtb_pkg::JTB_RTI;
         jtb_pkg::JTB_SEL_IR: state_nxt = tms_s ? jtb_pkg::JTB_TLR    : jtb_pkg::JTB_CAP_IR;
         jtb_pkg::JTB_CAP_IR: state_nxt = tms_s ? jtb_pkg::JTB_EX1_IR : jtb_pkg::JTB_SH_IR;
         jtb_pkg::JTB_SH_IR:  state_nxt = tms_s ? jtb_pkg::JTB_EX1_IR : jtb_pkg::JTB_SH_IR;
         jtb_pkg::JTB_EX1_IR: state_nxt = tms_s ? jtb_pkg::JTB_UPD_IR : jtb_pkg::JTB_PA_IR;
         jtb_pkg::JTB_PA_IR:  state_nxt = tms_s ? jtb_pkg::JTB_EX2_IR : jtb_pkg::JTB_PA_IR;
         jtb_pkg::JTB_EX2_IR: state_nxt = tms_s ? jtb_pkg::JTB_UPD_IR : jtb_pkg::JTB_SH_IR;
         jtb_pkg::JTB_UPD_IR: state_nxt = tms_s ? jtb_pkg::JTB_SEL_DR : jtb_pkg::JTB_RTI;
         default:             state_nxt = jtb_pkg::JTB_TLR;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in || !trst_s) state_r <= jtb_pkg::JTB_TLR; // R6
      else if (tck_rise) state_r <= state_nxt;                // R1 R10
   end

   // ***************************************************************
   // instruction and data registers
   // ***************************************************************
   logic [jtb_pkg::JTB_IR_W-1:0]  ir_r, ir_sr;
   logic [jtb_pkg::JTB_ID_W-1:0]  id_sr;
   logic [USER_W-1:0]             user_sr;
   logic                          bypass_r;
   logic                          pending_r;
   logic [USER_W-1:0]             pend_word_r;
   jtb_word_if #(.W(USER_W))      word_if ();

   always_ff @(posedge clock_in) begin
      if (!resetn_in || state_r == jtb_pkg::JTB_TLR) begin
         ir_r  <= jtb_pkg::JTB_IR_IDCODE;
         ir_sr <= '0;
      end else if (tck_rise) begin
         case (state_r)
            jtb_pkg::JTB_CAP_IR: ir_sr <= jtb_pkg::JTB_IR_CAPTURE;
            jtb_pkg::JTB_SH_IR:  ir_sr <= {tdi_s, ir_sr[jtb_pkg::JTB_IR_W-1:1]}; // R2 R10
            jtb_pkg::JTB_UPD_IR: ir_r  <= ir_sr;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         id_sr    <= '0;
         user_sr  <= '0;
         bypass_r <= 1'b0;
      end else if (tck_rise && state_r == jtb_pkg::JTB_CAP_DR) begin
         id_sr    <= ID_CODE;
         user_sr  <= USER_W'(pending_r);
         bypass_r <= 1'b0;
      end else if (tck_rise && state_r == jtb_pkg::JTB_SH_DR) begin
         case (ir_r)                                           // R2 R10
            jtb_pkg::JTB_IR_IDCODE: id_sr   <= {tdi_s, id_sr[jtb_pkg::JTB_ID_W-1:1]};
            jtb_pkg::JTB_IR_USER:   user_sr <= {tdi_s, user_sr[USER_W-1:1]};
            default:                bypass_r <= tdi_s;
         endcase
      end
   end

   // update word waits here until the buffer takes it; capture shows it waiting
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         pending_r   <= 1'b0;
         pend_word_r <= '0;
      end else if (tck_rise && state_r == jtb_pkg::JTB_UPD_DR && ir_r == jtb_pkg::JTB_IR_USER) begin
         pending_r   <= 1'b1;
         pend_word_r <= user_sr;
      end else if (word_if.ready) begin
         pending_r   <= 1'b0;
      end
   end

   assign word_if.valid = pending_r;
   assign word_if.data  = pend_word_r;

   jtb_word_buf #(.W(USER_W)) u_buf (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .fill      (word_if),
      .valid_out (word_valid_out),
      .data_out  (word_data_out),
      .ready_in  (word_ready_in)
   );

   // ***************************************************************
   // serial output, enable and pin float
   // ***************************************************************
   logic shifting;
   logic sel_bit;

   assign shifting = (state_r == jtb_pkg::JTB_SH_DR) || (state_r == jtb_pkg::JTB_SH_IR);

   always_comb begin
      if (state_r == jtb_pkg::JTB_SH_IR) sel_bit = ir_sr[0];
      else if (ir_r == jtb_pkg::JTB_IR_IDCODE) sel_bit = id_sr[0];
      else if (ir_r == jtb_pkg::JTB_IR_USER) sel_bit = user_sr[0];
      else sel_bit = bypass_r;
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) test_serial_data_out <= 1'b0;
      else if (tck_fall) test_serial_data_out <= sel_bit; // R3
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in || !trst_s) test_serial_data_oe_out <= 1'b0; // R6
      else if (tck_fall) test_serial_data_oe_out <= shifting;     // R4 R5
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) float_all_outputs_out <= 1'b0;
      else float_all_outputs_out <= !hiz_s && !trst_s;            // R9
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);

   reset_forces_tlr_a: assert property (!trst_s |=> state_r == jtb_pkg::JTB_TLR) // R6
      else $error("tap not in reset state under test reset");
   reset_floats_out_a: assert property (!trst_s |=> !test_serial_data_oe_out) // R6
      else $error("serial output driven under test reset");
   enable_on_fall_a: assert property ($changed(test_serial_data_oe_out) |-> $past(tck_fall) || !$past(trst_s)) // R5
      else $error("output enable changed without falling test clock");
   data_on_fall_a: assert property ($changed(test_serial_data_out) |-> $past(tck_fall)) // R3
      else $error("serial output changed without falling test clock");
   idle_floats_a: assert property (tck_fall && !shifting |=> !test_serial_data_oe_out) // R4
      else $error("serial output driven while nothing is shifting");
   state_on_rise_a: assert property (state_r != $past(state_r) |-> $past(tck_rise) || !$past(trst_s)) // R1
      else $error("state advanced without rising test clock");
   dr_shift_in_a: assert property (tck_rise && state_r == jtb_pkg::JTB_SH_DR && ir_r == jtb_pkg::JTB_IR_USER
      |=> user_sr[USER_W-1] == $past(tdi_s)) // R2
      else $error("data register did not take input bit");
   ir_shift_in_a: assert property (tck_rise && state_r == jtb_pkg::JTB_SH_IR
      |=> ir_sr[jtb_pkg::JTB_IR_W-1] == $past(tdi_s)) // R10
      else $error("instruction register did not take input bit");
   float_pins_a: assert property (!hiz_s && !trst_s |=> float_all_outputs_out) // R9
      else $error("pins not floated under float request");
   shift_drives_out_a: assert property (tck_fall && shifting && trst_s |=> test_serial_data_oe_out) // R4
      else $error("serial output floated while shifting");
   ir_update_a: assert property (tck_rise && state_r == jtb_pkg::JTB_UPD_IR |=> ir_r == $past(ir_sr)) // R10
      else $error("instruction not taken from shift register");
   id_capture_a: assert property (tck_rise && state_r == jtb_pkg::JTB_CAP_DR |=> id_sr == ID_CODE) // R10
      else $error("identity value not captured");
   user_capture_a: assert property (tck_rise && state_r == jtb_pkg::JTB_CAP_DR
      |=> user_sr[0] == $past(pending_r)) // R10
      else $error("pending flag not captured");
endmodule

//--- dv/jtb_ctrl_model.sv
`timescale 1ns/10ps
// ***************************************************************
// external scan controller: 200 ns test clock, idle low
// ***************************************************************
module jtb_ctrl_model (
   output logic      tck_out,
   output logic      tms_out,
   output logic      tdi_out,
   output logic      trst_n_out,
   input  wire logic tdo_in,
   input  wire logic tdo_oe_in
);
   logic tdo_wire;

   // undriven output line reads as float
   assign tdo_wire = tdo_oe_in ? tdo_in : 1'bz;

   initial begin
      tck_out    = 1'b0;
      tms_out    = 1'b1;
      tdi_out    = 1'b1;
      trst_n_out = 1'b0;
   end

   task automatic set_trst(input logic v);
      trst_n_out = v;
   endtask

   // sample output late in the high phase: it only moves after the fall
   task automatic bit_clk(input logic tms, input logic tdi, output logic tdo);
      tms_out = tms;
      tdi_out = tdi;
      #100 tck_out = 1'b1;
      #95 tdo = tdo_wire;
      #5 tck_out = 1'b0;
   endtask

   // from idle through capture, n shift bits, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic t;
      dout = 32'h00000000;
      bit_clk(1'b1, 1'b1, t);
      if (ir) begin
         bit_clk(1'b1, 1'b1, t);
      end
      bit_clk(1'b0, 1'b1, t);
      bit_clk(1'b0, 1'b1, t);
      for (int i = 0; i < n; i++) begin
         bit_clk(i == n - 1, din[i], t);
         dout[i] = t;
      end
      bit_clk(1'b1, 1'b1, t);
      bit_clk(1'b0, 1'b1, t);
   endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/10ps
module tb;
   logic        clock_in   = 1'b0;
   logic        resetn     = 1'b0;
   logic        float_n    = 1'b1;
   logic        ready      = 1'b0;
   logic        tck, tms, tdi, trst_n, tdo, oe, flt, valid;
   logic [7:0]  data;
   logic [7:0]  w;
   logic [31:0] got;
   logic [15:0] seed       = 16'h3194;
   logic [7:0]  q[$];
   int          mismatches = 0;
   int          n_compared = 0;
   int          cycles     = 0;
   int          since_fall = 0;
   logic        tck_q      = 1'b0;
   logic        oe_q       = 1'b0;
   logic        tdo_q      = 1'b0;

   always #12.5 clock_in = ~clock_in;

   jtb_ctrl_model u_ctrl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n), .tdo_in(tdo),
                          .tdo_oe_in(oe));
   jtb_test_port i_jtb_test_port (.clock_in(clock_in), .resetn_in(resetn), .test_port_clock_in(tck),
      .test_mode_select_in(tms), .test_serial_data_in(tdi), .test_port_reset_n_in(trst_n),
      .float_all_outputs_n_in(float_n), .test_serial_data_out(tdo), .test_serial_data_oe_out(oe),
      .float_all_outputs_out(flt), .word_valid_out(valid), .word_data_out(data), .word_ready_in(ready));

   // ***************************************************************
   // checking and closing
   // ***************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("compared %0d, mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic user_word(input logic [7:0] exp_cap);
      seed = lfsr_next(seed);
      w = seed[7:0];
      u_ctrl.scan(1'b0, 8, {24'h000000, w}, got);
      check(got, {24'h000000, exp_cap});
   endtask

   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      tck_q <= tck;
      oe_q <= oe;
      tdo_q <= tdo;
      since_fall <= (tck_q && !tck) ? 0 : since_fall + 1;
      if (resetn && trst_n && since_fall > 6 && (oe !== oe_q || (oe && tdo !== tdo_q))) begin
         check(32'h1, 32'h0);
      end
      if (valid && ready) begin
         if (q.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            check({24'h000000, data}, {24'h000000, q.pop_front()});
         end
      end
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end

   initial begin
      repeat (16) @(posedge clock_in);
      #1 resetn = 1'b1;
      repeat (4) @(posedge clock_in);
      check(flt, 1'b0);
      #1 u_ctrl.set_trst(1'b1);
      u_ctrl.bit_clk(1'b0, 1'b1, got[0]);
      u_ctrl.scan(1'b0, 32, 32'h0000_0000, got);
      check(got, jtb_pkg::JTB_ID_DEFAULT);
      check(oe, 1'b0);
      $display("test idcode done");
      u_ctrl.scan(1'b1, 4, {28'h0000000, jtb_pkg::JTB_IR_BYPASS}, got);
      check(got, {28'h0000000, jtb_pkg::JTB_IR_CAPTURE});
      seed = lfsr_next(seed);
      u_ctrl.scan(1'b0, 8, {24'h000000, seed[7:0]}, got);
      check(got, {24'h000000, seed[6:0], 1'b0});
      $display("test bypass done");
      // fill two entries, leave a third pending, then overwrite it
      u_ctrl.scan(1'b1, 4, {28'h0000000, jtb_pkg::JTB_IR_USER}, got);
      user_word(8'h00);
      q.push_back(w);
      user_word(8'h00);
      q.push_back(w);
      user_word(8'h00);
      q.push_back(w);
      user_word(8'h01);
      void'(q.pop_back());
      q.push_back(w);
      for (int i = 0; i < 400 && q.size() > 0; i++) begin
         @(posedge clock_in);
         #1 seed = lfsr_next(seed);
         ready = seed[0];
      end
      check(q.size(), 32'h0);
      ready = 1'b0;
      $display("test user words done");
      // abort a data shift by test reset
      u_ctrl.bit_clk(1'b1, 1'b1, got[0]);
      repeat (3) u_ctrl.bit_clk(1'b0, 1'b1, got[0]);
      check(oe, 1'b1);
      float_n = 1'b0;
      u_ctrl.set_trst(1'b0);
      repeat (6) @(posedge clock_in);
      check(oe, 1'b0);
      check(flt, 1'b1);
      #1 u_ctrl.set_trst(1'b1);
      repeat (6) @(posedge clock_in);
      check(flt, 1'b0);
      #1 float_n = 1'b1;
      u_ctrl.bit_clk(1'b0, 1'b1, got[0]);
      u_ctrl.scan(1'b0, 32, 32'hFFFF_FFFF, got);
      check(got, jtb_pkg::JTB_ID_DEFAULT);
      $display("test reset abort done");
      test_done();
   end
endmodule
